/* File: shared/pcs_sb_pkg.sv */
// Package for the PCS status indicators and serializer control sideband.
// Assumes one system clock; the register bus is classic Wishbone, 32-bit data.
package pcs_sb_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned ADR_W    = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_STAT = 8'h04;
  localparam logic [7:0]  OFS_ERRS = 8'h08;

  // ==========================================================
  // Control register fields
  localparam int unsigned CTRL_W        = 4;
  localparam int unsigned CTRL_PWRDN    = 0;
  localparam int unsigned CTRL_LOOP     = 1;
  localparam int unsigned CTRL_SGMII    = 2;
  localparam int unsigned CTRL_FDX      = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;

  // ==========================================================
  // Status register fields
  localparam int unsigned STAT_LINK     = 0;
  localparam int unsigned STAT_CRS      = 1;
  localparam int unsigned STAT_COL      = 2;
  localparam int unsigned STAT_AN_DONE  = 3;
  localparam int unsigned STAT_QUAD_PD  = 4;

  // ==========================================================
  // Error counter register fields
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned ERRS_DISP_LSB = 16;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [15:0] CNT_MAX       = 16'hffff;

  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Per-cycle events and levels from the receive and transmit state machines
  typedef struct packed {
    logic sync_ok;
    logic tx_active;
    logic rx_active;
    logic collision;
    logic an_done;
    logic char_err;
    logic disp_err;
  } pcs_event_t;

endpackage

/* File: verilog/pcs_status_and_serdes_ctrl.sv */
// Status indicators and serializer control sideband of a 1000BASE-X/SGMII PCS.
// Assumes the PCS core supplies per-cycle events synchronous to clk_i and that
// a Wishbone master reaches the control, status and error count registers.
`timescale 1ns/1ps

// How it works
// R1: Link indicator is high while link synchronization is achieved.
// R2: Carrier sense is high when transmit or receive path carries traffic.
// R3: Collision indicator goes high on a collision during a frame transfer.
// R4: Collision indicator stays low in 1000BASE-X mode or full-duplex SGMII.
// R5: Auto-negotiation indicator goes low once auto-negotiation has completed.
// R6: Invalid code group gives a character error pulse of exactly one cycle.
// R7: Running disparity error gives a disparity error pulse of exactly one cycle.
// R8: Serializer power-down output follows the software power-down selection.
// R9: Serializer power-down output exists only with an external serializer.
// R10: Serializer loopback output follows the software loopback selection.
// R11: Exported power-down output follows power-down selection in transceiver variants.
// R12: Transceiver quad is powered down whenever its power-down input is high.
// R13: Exported power-down pair exists only with transceiver and export option.
// R14: Outside party supplies the 125 MHz reference clock to transceiver variants.
// R15: Outside party supplies the receive ten-bit clock in serializer variants.
// R16: All outputs are registered and held low during reset.
module pcs_status_and_serdes_ctrl #(
  parameter bit EXT_SERDES   = 1'b1,
  parameter bit PWRDN_EXPORT = 1'b0
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire pcs_sb_pkg::wb_req_t    wb_req_i,
  output pcs_sb_pkg::wb_rsp_t         wb_rsp_o,
  input  wire pcs_sb_pkg::pcs_event_t pcs_ev_i,
  input  wire logic                   quad_pwrdn_req_i,
  output logic                        link_ind_o,
  output logic                        crs_ind_o,
  output logic                        col_ind_o,
  output logic                        autoneg_pending_indicator_o,
  output logic                        char_err_o,
  output logic                        disp_err_o,
  output logic                        serdes_pwrdn_o,
  output logic                        serializer_loop_ctrl_o,
  output logic                        pwrdn_export_o,
  output logic                        quad_pwrdn_o
);
  import pcs_sb_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic [CTRL_W-1:0] ctrl;
    logic              link;
    logic              crs;
    logic              col;
    logic              an_pend;
    logic              char_err;
    logic              disp_err;
    logic              sd_pwrdn;
    logic              sd_loop;
    logic              exp_pwrdn;
    logic              quad_pwrdn;
    logic [CNT_W-1:0]  char_cnt;
    logic [CNT_W-1:0]  disp_cnt;
  } state_t;

  localparam state_t STATE_RESET = '{
    ack: 1'b0, rdat: DATA_ZERO, ctrl: CTRL_RESET, link: 1'b0, crs: 1'b0,
    col: 1'b0, an_pend: 1'b0, char_err: 1'b0, disp_err: 1'b0,
    sd_pwrdn: 1'b0, sd_loop: 1'b0, exp_pwrdn: 1'b0, quad_pwrdn: 1'b0,
    char_cnt: '0, disp_cnt: '0
  };

  localparam bit HAS_EXPORT = !EXT_SERDES && PWRDN_EXPORT;

  state_t s_q;
  state_t s_d;

  // ==========================================================
  // Helpers
  function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] ofs);
    reg_hit = (adr == ofs);
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] cnt,
                                               input logic             ev);
    if (ev && cnt != CNT_MAX) begin
      sat_inc = cnt + CNT_ONE;
    end else begin
      sat_inc = cnt;
    end
  endfunction

  logic bus_go;
  logic bus_wr;
  logic std_mode;
  logic fdx_sgmii;

  assign bus_go    = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;
  assign bus_wr    = bus_go && wb_req_i.we;
  assign std_mode  = !s_q.ctrl[CTRL_SGMII];
  assign fdx_sgmii = s_q.ctrl[CTRL_SGMII] && s_q.ctrl[CTRL_FDX];

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Indicators
    s_d.link    = pcs_ev_i.sync_ok;                                 // [R1]
    s_d.crs     = pcs_ev_i.tx_active || pcs_ev_i.rx_active;         // [R2]
    s_d.col     = pcs_ev_i.collision && (pcs_ev_i.tx_active || pcs_ev_i.rx_active)
                  && !std_mode && !fdx_sgmii;                       // [R3] [R4]
    s_d.an_pend = !pcs_ev_i.an_done;                                // [R5]

    // One-cycle error pulses, one per detected code group
    s_d.char_err = pcs_ev_i.char_err;                               // [R6]
    s_d.disp_err = pcs_ev_i.disp_err;                               // [R7]

    // Serializer and transceiver controls
    s_d.sd_pwrdn   = EXT_SERDES && s_q.ctrl[CTRL_PWRDN];            // [R8] [R9]
    s_d.sd_loop    = s_q.ctrl[CTRL_LOOP];                           // [R10]
    s_d.exp_pwrdn  = HAS_EXPORT && s_q.ctrl[CTRL_PWRDN];            // [R11] [R13]
    s_d.quad_pwrdn = HAS_EXPORT && quad_pwrdn_req_i;                // [R12] [R13]

    // Bus slave: one wait state, ack for one cycle
    s_d.ack  = bus_go;
    s_d.rdat = DATA_ZERO;
    if (bus_go && !wb_req_i.we) begin
      if (reg_hit(wb_req_i.adr, OFS_CTRL)) begin
        s_d.rdat[CTRL_W-1:0] = s_q.ctrl;
      end else if (reg_hit(wb_req_i.adr, OFS_STAT)) begin
        s_d.rdat[STAT_LINK]    = s_q.link;
        s_d.rdat[STAT_CRS]     = s_q.crs;
        s_d.rdat[STAT_COL]     = s_q.col;
        s_d.rdat[STAT_AN_DONE] = !s_q.an_pend;
        s_d.rdat[STAT_QUAD_PD] = s_q.quad_pwrdn;
      end else if (reg_hit(wb_req_i.adr, OFS_ERRS)) begin
        s_d.rdat[CNT_W-1:0]                       = s_q.char_cnt;
        s_d.rdat[ERRS_DISP_LSB+CNT_W-1:ERRS_DISP_LSB] = s_q.disp_cnt;
      end
    end

    if (bus_wr && wb_req_i.sel[0] && reg_hit(wb_req_i.adr, OFS_CTRL)) begin
      s_d.ctrl = wb_req_i.dat[CTRL_W-1:0];
    end

    // Counters: a write clears, but an event in the same cycle still counts
    if (bus_wr && reg_hit(wb_req_i.adr, OFS_ERRS)) begin
      s_d.char_cnt = pcs_ev_i.char_err ? CNT_ONE : '0;
      s_d.disp_cnt = pcs_ev_i.disp_err ? CNT_ONE : '0;
    end else begin
      s_d.char_cnt = sat_inc(s_q.char_cnt, pcs_ev_i.char_err);
      s_d.disp_cnt = sat_inc(s_q.disp_cnt, pcs_ev_i.disp_err);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= STATE_RESET;                                           // [R16]
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign wb_rsp_o.ack                = s_q.ack;
  assign wb_rsp_o.dat                = s_q.rdat;
  assign link_ind_o                  = s_q.link;
  assign crs_ind_o                   = s_q.crs;
  assign col_ind_o                   = s_q.col;
  assign autoneg_pending_indicator_o = s_q.an_pend;
  assign char_err_o                  = s_q.char_err;
  assign disp_err_o                  = s_q.disp_err;
  assign serdes_pwrdn_o              = s_q.sd_pwrdn;
  assign serializer_loop_ctrl_o      = s_q.sd_loop;
  assign pwrdn_export_o              = s_q.exp_pwrdn;
  assign quad_pwrdn_o                = s_q.quad_pwrdn;

  // ==========================================================
  // Assertions
  property p_link;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (link_ind_o == $past(pcs_ev_i.sync_ok));
  endproperty
  a_link: assert property (p_link) else $error("link indicator wrong"); // [R1]

  property p_crs;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !pcs_ev_i.tx_active && !pcs_ev_i.rx_active) |=> !crs_ind_o;
  endproperty
  a_crs: assert property (p_crs) else $error("carrier sense without traffic"); // [R2]

  property p_col;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.collision && pcs_ev_i.tx_active && s_q.ctrl[CTRL_SGMII]
     && !s_q.ctrl[CTRL_FDX]) |=> col_ind_o;
  endproperty
  a_col: assert property (p_col) else $error("collision not shown"); // [R3]

  property p_col_low;
    @(posedge clk_i) disable iff (rst_i)
    (std_mode || fdx_sgmii) && ce_i |=> !col_ind_o;
  endproperty
  a_col_low: assert property (p_col_low) else $error("collision in full duplex"); // [R4]

  property p_an;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.an_done) |=> !autoneg_pending_indicator_o;
  endproperty
  a_an: assert property (p_an) else $error("autoneg indicator not low"); // [R5]

  property p_char;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.char_err) ##1 (ce_i && !pcs_ev_i.char_err)
      |=> $past(char_err_o, 1) && !char_err_o;
  endproperty
  a_char: assert property (p_char) else $error("char error pulse length"); // [R6]

  property p_disp;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.disp_err) ##1 (ce_i && !pcs_ev_i.disp_err)
      |=> $past(disp_err_o, 1) && !disp_err_o;
  endproperty
  a_disp: assert property (p_disp) else $error("disparity pulse length"); // [R7]

  property p_pwrdn;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (serdes_pwrdn_o == (EXT_SERDES && $past(s_q.ctrl[CTRL_PWRDN])));
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("serdes power-down wrong"); // [R8] [R9]

  property p_loop;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (serializer_loop_ctrl_o == $past(s_q.ctrl[CTRL_LOOP]));
  endproperty
  a_loop: assert property (p_loop) else $error("loopback control wrong"); // [R10]

  property p_export;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (pwrdn_export_o == (HAS_EXPORT && $past(s_q.ctrl[CTRL_PWRDN])));
  endproperty
  a_export: assert property (p_export) else $error("exported power-down wrong"); // [R11] [R13]

  property p_quad;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (quad_pwrdn_o == (HAS_EXPORT && $past(quad_pwrdn_req_i)));
  endproperty
  a_quad: assert property (p_quad) else $error("quad power-down wrong"); // [R12] [R13]

  property p_reset;
    @(posedge clk_i)
    rst_i |=> !(link_ind_o || crs_ind_o || col_ind_o || autoneg_pending_indicator_o
               || char_err_o || disp_err_o || serdes_pwrdn_o || serializer_loop_ctrl_o
               || pwrdn_export_o || quad_pwrdn_o || wb_rsp_o.ack);
  endproperty
  a_reset: assert property (p_reset) else $error("output high after reset"); // [R16]

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack) |=> wb_rsp_o.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack missing");

  // ==========================================================
  // Further assertions: indicators, bus, counters, clock enable
  property p_crs_high;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && (pcs_ev_i.tx_active || pcs_ev_i.rx_active)) |=> crs_ind_o;
  endproperty
  a_crs_high: assert property (p_crs_high) else $error("carrier sense missing"); // [R2]

  property p_col_idle;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !pcs_ev_i.tx_active && !pcs_ev_i.rx_active) |=> !col_ind_o;
  endproperty
  a_col_idle: assert property (p_col_idle) else $error("collision outside a frame"); // [R3]

  property p_an_pend;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !pcs_ev_i.an_done) |=> autoneg_pending_indicator_o;
  endproperty
  a_an_pend: assert property (p_an_pend) else $error("autoneg indicator low too early"); // [R5]

  property p_char_set;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.char_err) |=> char_err_o;
  endproperty
  a_char_set: assert property (p_char_set) else $error("char error pulse missing"); // [R6]

  property p_disp_set;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.disp_err) |=> disp_err_o;
  endproperty
  a_disp_set: assert property (p_disp_set) else $error("disparity pulse missing"); // [R7]

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_rsp_o.ack) |=> !wb_rsp_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack longer than one cycle");

  property p_rdat_idle;
    @(posedge clk_i) disable iff (rst_i)
    !wb_rsp_o.ack |-> (wb_rsp_o.dat == DATA_ZERO);
  endproperty
  a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside ack");

  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(s_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_ctrl_wr;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bus_wr && wb_req_i.sel[0] && reg_hit(wb_req_i.adr, OFS_CTRL))
      |=> (s_q.ctrl == $past(wb_req_i.dat[CTRL_W-1:0]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // [R8] [R10]

  property p_cnt_clear;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bus_wr && reg_hit(wb_req_i.adr, OFS_ERRS) && !pcs_ev_i.char_err)
      |=> (s_q.char_cnt == '0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("error count not cleared"); // [R6]

  property p_char_inc;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.char_err && !(bus_wr && reg_hit(wb_req_i.adr, OFS_ERRS))
     && s_q.char_cnt != CNT_MAX) |=> (s_q.char_cnt == $past(s_q.char_cnt) + CNT_ONE);
  endproperty
  a_char_inc: assert property (p_char_inc) else $error("char error not counted"); // [R6]

  property p_disp_inc;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pcs_ev_i.disp_err && !(bus_wr && reg_hit(wb_req_i.adr, OFS_ERRS))
     && s_q.disp_cnt != CNT_MAX) |=> (s_q.disp_cnt == $past(s_q.disp_cnt) + CNT_ONE);
  endproperty
  a_disp_inc: assert property (p_disp_inc) else $error("disparity error not counted"); // [R7]

endmodule

/* File: verif/xcvr_model.sv */
// Far-side transceiver model: returns the exported power-down, ORed with a forced request, as the quad request.
// Assumes clk_i stands in for the 125 MHz reference and receive clocks.
`timescale 1ns/1ps
module xcvr_model (
  input  wire logic clk_i,
  input  wire logic pwrdn_export_i,
  input  wire logic force_pd_i,
  output logic      quad_pwrdn_req_o
);
  // Quad powers down on export or on an outside request
  always @(posedge clk_i) begin
    quad_pwrdn_req_o <= pwrdn_export_i | force_pd_i;
  end
endmodule

/* File: verif/pcs_status_and_serdes_ctrl_test.sv */
// Testbench for the PCS status and serializer control sideband.
// Assumes both variants share one Wishbone request and one event stream.
`timescale 1ns/1ps
module pcs_status_and_serdes_ctrl_test;
  import pcs_sb_pkg::*;
  localparam int LNK = 9, CRS = 8, COL = 7, ANP = 6, CER = 5, DER = 4;
  localparam int SPD = 3, LOOP = 2, PEX = 1, QPD = 0;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wb_req_t     req = '0;
  wb_rsp_t     rsp;
  wb_rsp_t     rsp2;
  pcs_event_t  ev = '0;
  logic        force_pd = 1'b0;
  logic        quad_req;
  wire [9:0]   o1;
  wire [9:0]   o2;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        ce = 1'b1;
  logic [3:0]  modes [3] = '{4'h0, 4'h4, 4'hc};
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 clk_i = ~clk_i;

  pcs_status_and_serdes_ctrl i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req), .wb_rsp_o(rsp),
    .pcs_ev_i(ev), .quad_pwrdn_req_i(force_pd), .link_ind_o(o1[LNK]), .crs_ind_o(o1[CRS]),
    .col_ind_o(o1[COL]), .autoneg_pending_indicator_o(o1[ANP]), .char_err_o(o1[CER]),
    .disp_err_o(o1[DER]), .serdes_pwrdn_o(o1[SPD]), .serializer_loop_ctrl_o(o1[LOOP]),
    .pwrdn_export_o(o1[PEX]), .quad_pwrdn_o(o1[QPD]));

  pcs_status_and_serdes_ctrl #(.EXT_SERDES(1'b0), .PWRDN_EXPORT(1'b1)) i_dut_xcvr (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req), .wb_rsp_o(rsp2),
    .pcs_ev_i(ev), .quad_pwrdn_req_i(quad_req), .link_ind_o(o2[LNK]), .crs_ind_o(o2[CRS]),
    .col_ind_o(o2[COL]), .autoneg_pending_indicator_o(o2[ANP]), .char_err_o(o2[CER]),
    .disp_err_o(o2[DER]), .serdes_pwrdn_o(o2[SPD]), .serializer_loop_ctrl_o(o2[LOOP]),
    .pwrdn_export_o(o2[PEX]), .quad_pwrdn_o(o2[QPD]));

  xcvr_model i_model (.clk_i(clk_i), .pwrdn_export_i(o2[PEX]), .force_pd_i(force_pd),
    .quad_pwrdn_req_o(quad_req));

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1) @(posedge clk_i);
    rd = rsp.dat;
    rd2 = rsp2.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic ev_chk(input logic [6:0] e, input int idx, input logic exp, input string w);
    @(posedge clk_i) ev <= e;
    @(posedge clk_i) #1;
    chk(w, {31'h0, exp}, {31'h0, o1[idx]});
  endtask

  task automatic wait_chk(input string w, input logic [31:0] exp);
    repeat (3) @(posedge clk_i);
    #1;
    chk(w, exp, {12'h0, o1, o2});
  endtask

  task conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    chk("outputs in reset", 32'h0, {12'h0, o1, o2});
    @(posedge clk_i) rst_i <= 1'b0;
    ev_chk(7'h40, LNK, 1'b1, "link");
    ev_chk(7'h00, LNK, 1'b0, "link");
    ev_chk(7'h20, CRS, 1'b1, "crs tx");
    ev_chk(7'h10, CRS, 1'b1, "crs rx");
    ev_chk(7'h00, CRS, 1'b0, "crs idle");
    ev_chk(7'h00, ANP, 1'b1, "autoneg pending");
    ev_chk(7'h04, ANP, 1'b0, "autoneg done");
    $display("test indicators done");
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, OFS_CTRL, {28'h0, modes[i]});
      ev_chk(7'h28, COL, modes[i] == 4'h4, "collision");
      wb(1'b0, OFS_STAT, DATA_ZERO);
      chk("status", {29'h0, modes[i] == 4'h4, 2'b10}, rd);
    end
    wb(1'b0, OFS_CTRL, DATA_ZERO);
    chk("ctrl", 32'h0000_000c, rd);
    $display("test collision done");
    @(posedge clk_i) ev <= 7'h02;
    @(posedge clk_i) ev <= 7'h03;
    #1;
    chk("char pulse", 32'h1, {31'h0, o1[CER]});
    @(posedge clk_i) ev <= 7'h00;
    #1;
    chk("back to back pulses", 32'h3, {30'h0, o1[CER], o1[DER]});
    @(posedge clk_i) #1;
    chk("pulse end", 32'h0, {30'h0, o1[CER], o1[DER]});
    wb(1'b0, OFS_ERRS, DATA_ZERO);
    chk("error counts", 32'h0001_0002, rd);
    wb(1'b1, OFS_ERRS, DATA_ZERO);
    wb(1'b0, OFS_ERRS, DATA_ZERO);
    chk("cleared counts", DATA_ZERO, rd);
    wb(1'b0, 8'h0c, DATA_ZERO);
    chk("unmapped read", DATA_ZERO, rd);
    $display("test errors done");
    @(posedge clk_i) begin
      ce <= 1'b0;
      ev <= 7'h40;
    end
    repeat (2) @(posedge clk_i);
    #1;
    chk("link frozen", 32'h0, {31'h0, o1[LNK]});
    @(posedge clk_i) ce <= 1'b1;
    @(posedge clk_i) #1;
    chk("link after enable", 32'h1, {31'h0, o1[LNK]});
    @(posedge clk_i) ev <= 7'h00;
    $display("test clock enable done");
    wb(1'b1, OFS_CTRL, 32'h0000_0001);
    wait_chk("power-down", 32'h0001_2043);
    wb(1'b1, OFS_CTRL, 32'h0000_0002);
    wait_chk("loopback", 32'h0001_1044);
    @(posedge clk_i) force_pd <= 1'b1;
    wait_chk("quad request", 32'h0001_1045);
    wb(1'b0, OFS_STAT, DATA_ZERO);
    chk("quad status", 32'h0000_0010, rd2);
    chk("no quad status", DATA_ZERO, rd);
    $display("test serializer control done");
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) #1;
    chk("outputs in second reset", 32'h0, {12'h0, o1, o2});
    $display("test reset done");
    conclude();
  end
endmodule
